// ### common/bcd_loop_pkg.sv
// Functional notes
// - Decimal adjust after an add adds 00, 06, 60 or 66 and sets carry when 60 is included.
// - Decimal adjust after a subtract adds 00, FA, A0 or 9A and keeps the carry held before.
// - Decimal adjust sets carry per table, zero and sign from the byte, keeps D and H.
// - Decimal adjust with a direct register operand is opcode 40 plus the address byte.
// - An operand byte with upper nibble 1110 names working register or pair low nibble.
// - Byte decrement takes 6 cycles, opcode 00 direct and 01 indirect.
// - Byte decrement sets zero, sign and signed overflow and keeps carry, D and H.
// - Word decrement on an even register pair takes 10 cycles, opcode 80 and 81.
// - Word decrement sets zero, sign and overflow from the 16-bit result, keeps carry.
// - Opcode 8F clears only bit 7 of the interrupt mask control register at FB.
// - Opcode 9F sets bit 7 of the interrupt mask control register.
// - Opcode rA decrements working register r and branches by the displacement if nonzero.
// - The branch is relative to the byte after the instruction; zero falls through.
// - The loop takes 12 cycles taken, 10 not taken, and leaves every flag alone.
// - Only counter registers 04 to EF give defined loop results.
package bcd_loop_pkg;
  localparam logic [7:0] OP_DEC_R = 8'h00;
  localparam logic [7:0] OP_DEC_IR = 8'h01;
  localparam logic [7:0] OP_DA_R = 8'h40;
  localparam logic [7:0] OP_DA_IR = 8'h41;
  localparam logic [7:0] OP_WORD_DECREMENT_OP_RR = 8'h80;
  localparam logic [7:0] OP_WORD_DECREMENT_OP_IR = 8'h81;
  localparam logic [7:0] OP_IRQ_OFF = 8'h8F;
  localparam logic [7:0] OP_IRQ_ON = 8'h9F;
  localparam logic [3:0] OP_LOOP_LOW = 4'hA;
  localparam logic [3:0] WREG_NIBBLE = 4'hE;
  localparam logic [7:0] IMR_ADDR = 8'hFB;
  localparam logic [7:0] IMR_RESET = 8'h00;
  localparam int IMR_GLOBAL = 7;
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [7:0] DA_LOW_FIX = 8'h06;
  localparam logic [7:0] DA_HIGH_FIX = 8'h60;
  localparam logic [7:0] DA_SUB_LOW = 8'hFA;
  localparam logic [7:0] DA_SUB_HIGH = 8'hA0;
  localparam logic [3:0] CYC_DEC = 4'd6;
  localparam logic [3:0] CYC_WORD_DECREMENT_OP = 4'd10;
  localparam logic [3:0] CYC_DA = 4'd6;
  localparam logic [3:0] CYC_IRQ = 4'd6;
  localparam logic [3:0] CYC_LOOP_TAKEN = 4'd12;
  localparam logic [3:0] CYC_LOOP_FALL = 4'd10;

  typedef enum logic [6:0] {
    S_IDLE = 7'b000_0001,
    S_PTR = 7'b000_0010,
    S_RD = 7'b000_0100,
    S_CAP = 7'b000_1000,
    S_WR = 7'b001_0000,
    S_WRHI = 7'b010_0000,
    S_PAD = 7'b100_0000
  } state_t;

  typedef enum logic [2:0] {
    K_NONE, K_DEC, K_WORD_DECREMENT_OP, K_DA, K_LOOP, K_OFF, K_ON
  } kind_t;
endpackage : bcd_loop_pkg

// ### logic/bcd_adjust_decrement_loop_unit.sv
`timescale 1ns/1ns
module bcd_adjust_decrement_loop_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // instruction issue
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic [15:0] nextPc,
  input wire logic [7:0] flagsIn,
  input wire logic [3:0] wregBase,
  output logic busy,
  output logic done,
  // results
  output logic [7:0] flagsOut,
  output logic flagsWe,
  output logic [15:0] pcOut,
  output logic pcWe,
  // register file port
  output logic [7:0] regAddr,
  output logic regRe,
  output logic regWe,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // interrupt mask control register
  input wire logic ctlWe,
  input wire logic [7:0] ctlAddr,
  input wire logic [7:0] ctlWdata,
  output logic [7:0] interruptMaskControl
);
  import bcd_loop_pkg::*;

  function automatic bcd_loop_pkg::kind_t decodeOp(input logic [7:0] op);
    kind_t k;
    k = K_NONE;
    if (op[3:0] == OP_LOOP_LOW) begin
      k = K_LOOP;
    end else if (op == OP_DEC_R || op == OP_DEC_IR) begin
      k = K_DEC;
    end else if (op == OP_DA_R || op == OP_DA_IR) begin
      k = K_DA;
    end else if (op == OP_WORD_DECREMENT_OP_RR || op == OP_WORD_DECREMENT_OP_IR) begin
      k = K_WORD_DECREMENT_OP;
    end else if (op == OP_IRQ_OFF) begin
      k = K_OFF;
    end else if (op == OP_IRQ_ON) begin
      k = K_ON;
    end
    return k;
  endfunction : decodeOp

  function automatic logic [7:0] wregAddr(input logic [7:0] b, input logic [3:0] base);
    return (b[7:4] == WREG_NIBBLE) ? {base, b[3:0]} : b;
  endfunction : wregAddr

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and datapath

  state_t state_q, state_d;
  kind_t kind_q, kind_d, k;
  logic [3:0] cnt_q, cnt_d, last_q, last_d;
  logic ind_q, ind_d;
  logic [7:0] a_q, a_d, hi_q, hi_d, disp_q, disp_d, flg_q, flg_d;
  logic [7:0] fOut_q, fOut_d;
  logic fWe_q, fWe_d, pcWe_q, pcWe_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] bres, dres, daCorr;
  logic [15:0] wres, wval;
  logic lowAdj, hiAdj, daCarry, taken;

  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    last_d = last_q;
    ind_d = ind_q;
    a_d = a_q;
    hi_d = hi_q;
    disp_d = disp_q;
    flg_d = flg_q;
    fOut_d = fOut_q;
    fWe_d = fWe_q;
    pc_d = pc_q;
    pcWe_d = pcWe_q;
    regAddr = a_q;
    regRe = 1'b0;
    regWe = 1'b0;
    regWdata = 8'h00;
    done = 1'b0;
    k = decodeOp(opcode);
    bres = hi_q - 8'h01;
    wval = {hi_q, regRdata};
    wres = wval - 16'h0001;
    taken = (bres != 8'h00);
    lowAdj = 1'b0;
    hiAdj = 1'b0;
    // decimal adjust correction, subtract form keeps the old carry
    if (flg_q[FLAG_D]) begin
      daCorr = (flg_q[FLAG_H] ? DA_SUB_LOW : 8'h00)
             + (flg_q[FLAG_C] ? DA_SUB_HIGH : 8'h00);
      daCarry = flg_q[FLAG_C];
    end else begin
      lowAdj = flg_q[FLAG_H] | (hi_q[3:0] > 4'h9);
      hiAdj = flg_q[FLAG_C] | (hi_q[7:4] > 4'h9)
            | ((hi_q[7:4] > 4'h8) & (hi_q[3:0] > 4'h9));
      daCorr = (lowAdj ? DA_LOW_FIX : 8'h00) | (hiAdj ? DA_HIGH_FIX : 8'h00);
      daCarry = hiAdj;
    end
    dres = hi_q + daCorr;
    if (state_q != S_IDLE) begin
      cnt_d = cnt_q + 4'd1;
    end
    unique case (state_q)
      S_IDLE: begin
        if (start && k != K_NONE) begin
          kind_d = k;
          cnt_d = 4'd1;
          disp_d = operand;
          flg_d = flagsIn;
          fOut_d = flagsIn;
          fWe_d = 1'b0;
          pcWe_d = 1'b0;
          pc_d = nextPc;
          ind_d = opcode[0] & (k == K_DEC || k == K_DA || k == K_WORD_DECREMENT_OP);
          // counter outside 04..EF is left to software
          a_d = (k == K_LOOP) ? {wregBase, opcode[7:4]} : wregAddr(operand, wregBase);
          unique case (k)
            K_DEC: last_d = CYC_DEC - 4'd1;
            K_WORD_DECREMENT_OP: last_d = CYC_WORD_DECREMENT_OP - 4'd1;
            K_DA: last_d = CYC_DA - 4'd1;
            K_LOOP: last_d = CYC_LOOP_TAKEN - 4'd1;
            default: last_d = CYC_IRQ - 4'd1;
          endcase
          if (k == K_OFF || k == K_ON) begin
            state_d = S_PAD;
          end else if (opcode[0] && k != K_LOOP) begin
            state_d = S_PTR;
          end else begin
            state_d = S_RD;
          end
        end
      end
      S_PTR: begin
        regRe = 1'b1;
        state_d = S_RD;
      end
      S_RD: begin
        regRe = 1'b1;
        if (ind_q) begin
          regAddr = regRdata;
          a_d = regRdata;
          ind_d = 1'b0;
        end
        state_d = S_CAP;
      end
      S_CAP: begin
        hi_d = regRdata;
        if (kind_q == K_WORD_DECREMENT_OP) begin
          regRe = 1'b1;
          regAddr = a_q + 8'h01;
        end
        state_d = S_WR;
      end
      S_WR: begin
        regWe = 1'b1;
        state_d = S_PAD;
        unique case (kind_q)
          K_WORD_DECREMENT_OP: begin
            regAddr = a_q + 8'h01;
            regWdata = wres[7:0];
            hi_d = wres[15:8];
            fOut_d[FLAG_Z] = (wres == 16'h0000);
            fOut_d[FLAG_S] = wres[15];
            fOut_d[FLAG_V] = (wval == 16'h8000);
            fWe_d = 1'b1;
            state_d = S_WRHI;
          end
          K_DA: begin
            regWdata = dres;
            fOut_d[FLAG_C] = daCarry;
            fOut_d[FLAG_Z] = (dres == 8'h00);
            fOut_d[FLAG_S] = dres[7];
            fWe_d = 1'b1;
          end
          K_LOOP: begin
            regWdata = bres;
            pcWe_d = taken;
            if (taken) begin
              pc_d = pc_q + {{8{disp_q[7]}}, disp_q};
              last_d = CYC_LOOP_TAKEN - 4'd1;
            end else begin
              last_d = CYC_LOOP_FALL - 4'd1;
            end
          end
          default: begin
            regWdata = bres;
            fOut_d[FLAG_Z] = (bres == 8'h00);
            fOut_d[FLAG_S] = bres[7];
            fOut_d[FLAG_V] = (hi_q == 8'h80);
            fWe_d = 1'b1;
          end
        endcase
      end
      S_WRHI: begin
        regWe = 1'b1;
        regWdata = hi_q;
        state_d = S_PAD;
      end
      S_PAD: begin
        if (cnt_q == last_q) begin
          done = 1'b1;
          state_d = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      kind_q <= K_NONE;
      cnt_q <= 4'd0;
      last_q <= 4'd0;
      ind_q <= 1'b0;
      a_q <= 8'h00;
      hi_q <= 8'h00;
      disp_q <= 8'h00;
      flg_q <= 8'h00;
      fOut_q <= 8'h00;
      fWe_q <= 1'b0;
      pc_q <= 16'h0000;
      pcWe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      ind_q <= ind_d;
      a_q <= a_d;
      hi_q <= hi_d;
      disp_q <= disp_d;
      flg_q <= flg_d;
      fOut_q <= fOut_d;
      fWe_q <= fWe_d;
      pc_q <= pc_d;
      pcWe_q <= pcWe_d;
    end
  end

  assign busy = (state_q != S_IDLE);
  assign flagsOut = fOut_q;
  assign pcOut = pc_q;
  assign flagsWe = done & fWe_q;
  assign pcWe = done & pcWe_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt mask control register

  logic [7:0] imr_q, imr_d;

  always_comb begin
    imr_d = imr_q;
    if (ctlWe && ctlAddr == IMR_ADDR) begin
      imr_d = ctlWdata;
    end
    if (done && kind_q == K_OFF) begin
      imr_d[IMR_GLOBAL] = 1'b0;
    end
    if (done && kind_q == K_ON) begin
      imr_d[IMR_GLOBAL] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      imr_q <= IMR_RESET;
    end else begin
      imr_q <= imr_d;
    end
  end

  assign interruptMaskControl = imr_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence issue_s(logic [7:0] op);
    start && !busy && opcode == op;
  endsequence

  sequence loop_s;
    start && !busy && opcode[3:0] == OP_LOOP_LOW;
  endsequence

  dec_cycles_a: assert property ((issue_s(OP_DEC_R) or issue_s(OP_DEC_IR)) |->
    ##5 done && flagsWe) else $error("byte decrement not done in 6 cycles");
  dec_carry_a: assert property (issue_s(OP_DEC_R) |->
    ##5 flagsOut[FLAG_C] == $past(flagsIn[FLAG_C], 5)) else $error("decrement moved carry");
  word_decrement_op_cycles_a: assert property (issue_s(OP_WORD_DECREMENT_OP_RR) |->
    ##9 done && flagsWe && flagsOut[FLAG_C] == $past(flagsIn[FLAG_C], 9))
    else $error("word decrement timing or carry wrong");
  loop_taken_a: assert property ((done && pcWe) |->
    $past(start && !busy, 11)) else $error("taken loop not 12 cycles");
  loop_fall_a: assert property (loop_s ##9 done |-> !pcWe && !flagsWe)
    else $error("fall-through loop wrong");
  wreg_decode_a: assert property ((issue_s(OP_DEC_R) ##0 operand[7:4] == WREG_NIBBLE) |->
    ##1 regRe && regAddr == $past({wregBase, operand[3:0]})) else $error("working reg decode");
  indirect_addr_a: assert property (issue_s(OP_DEC_IR) |->
    ##2 regRe ##2 regWe && regAddr == $past(regRdata, 2))
    else $error("indirect address not used");
  irq_off_a: assert property (issue_s(OP_IRQ_OFF) ##0 (!ctlWe)[*7] |->
    !imr_q[IMR_GLOBAL] && imr_q[6:0] == $past(imr_q[6:0], 6)) else $error("global off wrong");
  irq_on_a: assert property (issue_s(OP_IRQ_ON) ##0 (!ctlWe)[*7] |->
    imr_q[IMR_GLOBAL]) else $error("global on wrong");
  da_sub_carry_a: assert property ((issue_s(OP_DA_R) ##0 flagsIn[FLAG_D]) |->
    ##5 flagsOut[FLAG_C] == $past(flagsIn[FLAG_C], 5)) else $error("adjust carry changed");
  da_add_carry_a: assert property (issue_s(OP_DA_R) ##0 !flagsIn[FLAG_D]
    ##0 flagsIn[FLAG_C] |-> ##5 flagsOut[FLAG_C]) else $error("adjust add lost carry");
endmodule : bcd_adjust_decrement_loop_unit

// ### bench/bcd_adjust_decrement_loop_unit_bench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module bcd_adjust_decrement_loop_unit_bench;
  import bcd_loop_pkg::*;
  logic mclk = 0;
  logic sysRst = 1;
  logic start = 0;
  logic [7:0] opcode = 0;
  logic [7:0] operand = 0;
  logic [15:0] nextPc = 0;
  logic [7:0] flagsIn = 0;
  logic [3:0] wregBase = 0;
  logic busy, done, flagsWe, pcWe, regRe, regWe;
  logic [7:0] flagsOut, regAddr, regWdata, interruptMaskControl;
  logic [15:0] pcOut;
  logic [7:0] regRdata = 8'h00;
  logic ctlWe = 0;
  logic [7:0] ctlAddr = 0;
  logic [7:0] ctlWdata = 0;
  logic [7:0] rf [256];
  logic fw, pw;
  logic [7:0] fo;
  logic [15:0] po;
  int n;
  int errors = 0;
  int checks = 0;
  // value, flags in, adjusted value, carry after
  localparam logic [31:0] DA_TAB [14] = '{
    32'h3C00_4200, 32'h9900_9900, 32'h9204_9800, 32'hA500_0501, 32'h9B00_0101,
    32'h9A00_0001, 32'hA204_0801, 32'h1580_7501, 32'h2A80_9001, 32'h3284_9801,
    32'h4508_4500, 32'h2F0C_2900, 32'h8588_2501, 32'h7B8C_1501};

  bcd_adjust_decrement_loop_unit bcd_adjust_decrement_loop_unit_i (
    .mclk(mclk), .sys_rst(sysRst), .start(start), .opcode(opcode), .operand(operand),
    .nextPc(nextPc), .flagsIn(flagsIn), .wregBase(wregBase), .busy(busy), .done(done),
    .flagsOut(flagsOut), .flagsWe(flagsWe), .pcOut(pcOut), .pcWe(pcWe),
    .regAddr(regAddr), .regRe(regRe), .regWe(regWe), .regWdata(regWdata),
    .regRdata(regRdata), .ctlWe(ctlWe), .ctlAddr(ctlAddr), .ctlWdata(ctlWdata),
    .interruptMaskControl(interruptMaskControl));

  always #5 mclk = ~mclk;

  // register file, one cycle read latency, stale data inverted when idle
  always @(posedge mclk) begin
    if (regWe) rf[regAddr] <= regWdata;
    regRdata <= regRe ? rf[regAddr] : ~regRdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task issue(input logic [7:0] op, od, fl, input logic [15:0] pc, input logic [3:0] wb);
    @(posedge mclk);
    start <= 1;
    opcode <= op;
    operand <= od;
    flagsIn <= fl;
    nextPc <= pc;
    wregBase <= wb;
    @(posedge mclk);
    start <= 0;
    n = 1;
    #1;
    `CHK("busy", 1'b1, busy)
    while (done !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
      #1;
    end
    if (done !== 1'b1) errors++;
    fw = flagsWe;
    fo = flagsOut;
    pw = pcWe;
    po = pcOut;
  endtask : issue

  ////////////////////////////////////////////////////////////////////////////
  task t_dec;
    rf[8'h36] = 8'h80;
    issue(OP_DEC_R, 8'hE6, 8'hAC, 16'h0, 4'h3);
    `CHK("dec cycles", 5, n)
    `CHK("dec value", 8'h7F, rf[8'h36])
    `CHK("dec flags", 8'h9C, fo)
    `CHK("dec flagsWe", 1'b1, fw)
    rf[8'hB3] = 8'hCB;
    rf[8'hCB] = 8'h01;
    issue(OP_DEC_IR, 8'hB3, 8'h00, 16'h0, 4'h3);
    `CHK("deci value", 8'h00, rf[8'hCB])
    `CHK("deci ptr", 8'hCB, rf[8'hB3])
    `CHK("deci flags", 8'h40, fo)
  endtask : t_dec

  task t_word_decrement_op;
    rf[8'h30] = 8'h0A;
    rf[8'h31] = 8'hF2;
    issue(OP_WORD_DECREMENT_OP_RR, 8'h30, 8'h00, 16'h0, 4'h3);
    `CHK("word_decrement_op cycles", 9, n)
    `CHK("word_decrement_op value", 16'h0AF1, {rf[8'h30], rf[8'h31]})
    `CHK("word_decrement_op flags", 8'h00, fo)
    rf[8'h40] = 8'h30;
    rf[8'h30] = 8'hFA;
    rf[8'h31] = 8'hF3;
    issue(OP_WORD_DECREMENT_OP_IR, 8'hE0, 8'h00, 16'h0, 4'h4);
    `CHK("decwi value", 16'hFAF2, {rf[8'h30], rf[8'h31]})
    `CHK("decwi flags", 8'h20, fo)
    rf[8'h50] = 8'h80;
    rf[8'h51] = 8'h00;
    issue(OP_WORD_DECREMENT_OP_RR, 8'h50, 8'h80, 16'h0, 4'h4);
    `CHK("decwv value", 16'h7FFF, {rf[8'h50], rf[8'h51]})
    `CHK("decwv flags", 8'h90, fo)
  endtask : t_word_decrement_op

  task t_da;
    logic [31:0] e;
    logic [7:0] fx;
    for (int i = 0; i < 14; i++) begin
      e = DA_TAB[i];
      rf[8'h65] = e[31:24];
      rf[8'h20] = 8'h65;
      if (i[0]) issue(OP_DA_IR, 8'h20, e[23:16], 16'h0, 4'h6);
      else issue(OP_DA_R, 8'hE5, e[23:16], 16'h0, 4'h6);
      fx = {e[0], e[15:8] == 8'h00, e[15], e[20:16]};
      `CHK("da value", e[15:8], rf[8'h65])
      `CHK("da flags", fx, fo)
    end
  endtask : t_da

  task t_mask;
    `CHK("mask reset", 8'h00, interruptMaskControl)
    @(posedge mclk);
    ctlWe <= 1;
    ctlAddr <= IMR_ADDR;
    ctlWdata <= 8'h8A;
    @(posedge mclk);
    ctlAddr <= 8'hFA;
    ctlWdata <= 8'hFF;
    @(posedge mclk);
    ctlWe <= 0;
    issue(OP_IRQ_OFF, 8'h00, 8'h00, 16'h0, 4'h0);
    @(posedge mclk);
    #1;
    `CHK("irq off", 8'h0A, interruptMaskControl)
    issue(OP_IRQ_ON, 8'h00, 8'h00, 16'h0, 4'h0);
    @(posedge mclk);
    #1;
    `CHK("irq on", 8'h8A, interruptMaskControl)
  endtask : t_mask

  task t_loop;
    rf[8'h26] = 8'h02;
    issue({4'h6, OP_LOOP_LOW}, 8'hF0, 8'hFF, 16'h1000, 4'h2);
    `CHK("loop taken cycles", 11, n)
    `CHK("loop taken pcWe", 1'b1, pw)
    `CHK("loop back pc", 16'h0FF0, po)
    `CHK("loop count", 8'h01, rf[8'h26])
    `CHK("loop flagsWe", 1'b0, fw)
    issue({4'h6, OP_LOOP_LOW}, 8'h7F, 8'hFF, 16'h1000, 4'h2);
    `CHK("loop fall cycles", 9, n)
    `CHK("loop fall pcWe", 1'b0, pw)
    `CHK("loop zero", 8'h00, rf[8'h26])
    rf[8'h2F] = 8'h05;
    issue({4'hF, OP_LOOP_LOW}, 8'h7F, 8'h00, 16'h1000, 4'h2);
    `CHK("loop fwd pc", 16'h107F, po)
  endtask : t_loop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    sysRst <= 0;
    t_mask();
    t_dec();
    t_word_decrement_op();
    t_da();
    t_loop();
    tally_and_finish();
  end

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule : bcd_adjust_decrement_loop_unit_bench
